// ==== dv/smpdc_asserts.sv ====
// Checker on the dither control top ports.
// Assumes a bind into smpdc_top with the same WDOG_CYCLES.
`timescale 1ns/1ps
module smpdc_asserts
  import smpdc_pkg::*;
#(
  parameter int WDOG_CYCLES = WDOG_CYC
)
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Watched ports
  input wire logic        overvoltage_comparator,
  input wire logic [9:0]  duty_out,
  input wire logic        osc_halt,
  input wire logic        dither_req,
  input wire logic        cmp_event_en,
  input wire logic        dir_up,
  input wire logic [15:0] power_prev,
  input wire logic        wdog_reset
);
  // ******
  // Rules
  // ******
  int idle_r;

  // Cycles since the last pass or watchdog pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) idle_r <= 0;
    else idle_r <= (dither_req || wdog_reset) ? 0 : idle_r + 1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Request spans the four pass steps, then the mask reopens
  sequence s_pass;
    dither_req [*4] ##1 (!dither_req && cmp_event_en);
  endsequence
  property p_mask; $rose(dither_req) |-> !cmp_event_en; endproperty
  a_mask: assert property (p_mask) else $error("mask open");
  property p_pass; $rose(dither_req) |-> s_pass; endproperty
  a_pass: assert property (p_pass) else $error("pass shape");
  property p_lsb; duty_out[1:0] == 2'h0; endproperty
  a_lsb: assert property (p_lsb) else $error("duty low bits");
  property p_step;
    $changed(duty_out) && !wdog_reset |->
      8'(duty_out[9:2] - $past(duty_out[9:2])) inside {8'h01, 8'hFF};
  endproperty
  a_step: assert property (p_step) else $error("step size");
  property p_halt;
    $rose(overvoltage_comparator) |-> ##[1:4] osc_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt");
  property p_state;
    $changed({dir_up, power_prev}) && !wdog_reset |-> $past(dither_req);
  endproperty
  a_state: assert property (p_state) else $error("stray update");
  property p_wdog;
    (idle_r < WDOG_CYCLES + 8) and
      ($rose(wdog_reset) |-> idle_r > WDOG_CYCLES - 8);
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog time");
  property p_clear;
    $fell(wdog_reset) |-> duty_out == 10'h000 && !dir_up &&
      power_prev == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("not cleared");
endmodule : smpdc_asserts

bind smpdc_top smpdc_asserts #(.WDOG_CYCLES(WDOG_CYCLES)) u_chk (
  .clk(clk), .nrst(nrst), .overvoltage_comparator(overvoltage_comparator),
  .duty_out(duty_out), .osc_halt(osc_halt), .dither_req(dither_req),
  .cmp_event_en(cmp_event_en), .dir_up(dir_up),
  .power_prev(power_prev), .wdog_reset(wdog_reset));

// ==== dv/smpdc_partner.sv ====
// Model of the boost stage current comparator.
// Assumes kick comes from the bench on clk.
`timescale 1ns/1ps
module smpdc_partner (
  // Clock and command
  input wire logic clk,
  input wire logic kick,
  input wire logic osc_halt,
  // Comparator pin
  output logic     current_comparator
);
  // One edge per kick; a halted stage stays still
  initial current_comparator = 1'h0;
  always @(posedge clk) begin
    if (kick && !osc_halt) current_comparator <= !current_comparator;
  end
endmodule : smpdc_partner

// ==== dv/testbench.sv ====
// Bench: tracking passes, trim and watchdog.
// Assumes the partner model and the bound checker.
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'h0, nrst = 1'h0, kick = 1'h0, ov = 1'h0;
  logic        en = 1'h1, cc, halt, req, mask, dir, wdr, e_dir, e_first;
  logic [7:0]  volt = 8'h00, e_set;
  logic [9:0]  duty;
  logic [15:0] prev, e_prev;
  int          err_count = 0, tests_run = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  smpdc_partner u_far (.clk(clk), .kick(kick), .osc_halt(halt),
    .current_comparator(cc));
  smpdc_top #(.WDOG_CYCLES(200)) dut (.clk(clk), .nrst(nrst),
    .current_comparator(cc), .overvoltage_comparator(ov),
    .panel_volt(volt), .current_comparator_en(en), .duty_out(duty),
    .osc_halt(halt), .dither_req(req), .cmp_event_en(mask),
    .dir_up(dir), .power_prev(prev), .wdog_reset(wdr));

  // ******
  // Tasks
  // ******
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk

  task automatic wt(logic w, logic v);
    int i;
    for (i = 0; i < 400 && (w ? wdr : req) !== v; i++) @(negedge clk);
    if (i == 400) begin
      chk("wait", v, w ? wdr : req);
      report_and_stop();
    end
  endtask : wt

  task automatic pass(logic [7:0] v);
    logic [15:0] p;
    logic        up;
    @(posedge clk) volt <= v;
    repeat (3) @(posedge clk);
    kick <= 1'h1;
    @(posedge clk) kick <= 1'h0;
    wt(1'h0, 1'h1);
    wt(1'h0, 1'h0);
    repeat (2) @(negedge clk);
    p = e_set * v;
    up = e_first || (p > e_prev ? e_dir : !e_dir);
    if (up && e_set != 8'hFF) e_set++;
    if (!up && e_set != 8'h00) e_set--;
    {e_dir, e_prev, e_first} = {up, p, 1'h0};
    chk("duty", {e_set, 2'h0}, duty);
    chk("dir", e_dir, dir);
    chk("prev", e_prev, prev);
    chk("mask", 1'h1, mask);
  endtask : pass

  // Main sequence
  initial begin
    {e_set, e_dir, e_prev, e_first} = {8'h00, 1'h0, 16'h0000, 1'h1};
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    @(negedge clk);
    chk("prev", 16'h0000, prev);
    @(posedge clk) en <= 1'h0;
    @(posedge clk) kick <= 1'h1;
    @(posedge clk) kick <= 1'h0;
    repeat (10) @(negedge clk);
    chk("req", 1'h0, req);
    @(posedge clk) en <= 1'h1;
    $display("test gate done");
    pass(8'h80);
    repeat (256) pass(8'hFF);
    pass(8'hFF);
    pass(8'h80);
    pass(8'hFF);
    $display("test tracking done");
    @(posedge clk) ov <= 1'h1;
    repeat (6) @(negedge clk);
    e_set--;
    chk("halt", 1'h1, halt);
    chk("duty", {e_set, 2'h0}, duty);
    @(posedge clk) ov <= 1'h0;
    repeat (6) @(negedge clk);
    chk("halt", 1'h0, halt);
    pass(8'hFF);
    $display("test trim done");
    wt(1'h1, 1'h1);
    wt(1'h1, 1'h0);
    @(negedge clk);
    chk("duty", 10'h000, duty);
    chk("dir", 1'h0, dir);
    {e_set, e_dir, e_prev, e_first} = {8'h00, 1'h0, 16'h0000, 1'h1};
    pass(8'h10);
    $display("test watchdog done");
    report_and_stop();
  end
endmodule : testbench

// ==== hw/smpdc_pkg.sv ====
// Constants and types shared by the max power dither control block.
// Assumes one 40 MHz clock and an active low asynchronous reset.
//
// What this block does
// - Power is 8-bit setting times 8-bit voltage
// - Only the sign of power change matters
// - First pass uses minimum setting, present voltage
// - After first pass raise setting, set direction
// - Power rose: step again along the direction
// - Power fell: step opposite and update direction
// - Reduction acts only on over-voltage event
// - Over-voltage halts oscillation, lowers setting one step
// - Oscillation resumes at reduced setting afterwards
// - Comparator enabled means its change event enabled
// - Comparator event sets dither request, masks event
// - Request runs a pass and restarts watchdog
// - Pass end clears request, unmasks comparator event
// - Watchdog expiry resets control state, setting and outputs, not the synchronisers
// - Setting is upper 8 bits of 10-bit duty
// - Over-voltage comparator high means output too high
package smpdc_pkg;

  localparam int          SET_W      = 8;
  localparam int          DUTY_W     = 10;
  localparam int          VOLT_W     = 8;
  localparam int          PWR_W      = 16;
  localparam logic [7:0]  SET_MIN    = 8'h00;
  localparam logic [7:0]  SET_MAX    = 8'hFF;
  localparam logic [7:0]  SET_STEP   = 8'h01;
  localparam logic [1:0]  DUTY_LSB   = 2'h0;
  localparam logic [15:0] PWR_RST    = 16'h0000;
  localparam int          WDOG_MS    = 18;
  localparam int          CLK_KHZ    = 40000;
  localparam int          WDOG_CYC   = WDOG_MS * CLK_KHZ;
  localparam int          WDOG_W     = 20;
  localparam logic [7:0]  PULSE_CYC  = 8'h04;

  // Tracking pass sequencer states
  typedef enum logic [1:0] {
    SMPDC_IDLE    = 2'b00,
    SMPDC_CALC    = 2'b01,
    SMPDC_DECIDE  = 2'b10,
    SMPDC_FINISH  = 2'b11
  } smpdc_state_type;

endpackage : smpdc_pkg

// ==== hw/smpdc_setting.sv ====
// Saturating 8-bit current setting register.
// Assumes at most one of up or down per cycle; down wins if both, except at minimum where up is taken.
`timescale 1ns/1ps
module smpdc_setting
  import smpdc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Step requests
  smpdc_step_if.reg_side stp
);

  logic [7:0] set_r;
  logic [7:0] set_nxt;
  logic       at_min;
  logic       at_max;

  // Saturation limits
  assign at_min  = (set_r == SET_MIN);
  assign at_max  = (set_r == SET_MAX);
  assign set_nxt = (stp.down && !at_min) ? set_r - SET_STEP :
                   (stp.up && !at_max)   ? set_r + SET_STEP : set_r;
  assign stp.setting = set_r;

  // Setting register, starts at minimum
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      set_r <= SET_MIN;
    end else begin
      set_r <= set_nxt;
    end
  end

endmodule : smpdc_setting

// ==== hw/smpdc_step_if.sv ====
// Interface carrying a step request to the setting register module.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface smpdc_step_if;
  logic       up;
  logic       down;
  logic [7:0] setting;
  modport ctrl (output up, output down, input setting);
  modport reg_side (input up, input down, output setting);
endinterface : smpdc_step_if

// ==== hw/smpdc_top.sv ====
// Max power point dither control: tracking passes, over-voltage trim,
// comparator event gating and watchdog.
// Assumes comparator and sampler inputs are asynchronous pins.
`timescale 1ns/1ps
module smpdc_top
  import smpdc_pkg::*;
#(
  parameter int WDOG_CYCLES = WDOG_CYC
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Comparators and sampler
  input  wire logic              current_comparator,
  input  wire logic              overvoltage_comparator,
  input  wire logic [VOLT_W-1:0] panel_volt,
  // Control
  input  wire logic              current_comparator_en,
  // Outputs to reference and converter
  output logic [DUTY_W-1:0]      duty_out,
  output logic                   osc_halt,
  output logic                   dither_req,
  output logic                   cmp_event_en,
  output logic                   dir_up,
  output logic [PWR_W-1:0]       power_prev,
  output logic                   wdog_reset
);

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  logic       cc_s1_r, cc_s2_r, cc_s3_r;
  logic       ov_s1_r, ov_s2_r, ov_s3_r;
  logic       en_s1_r, en_s2_r;
  logic [7:0] v_s1_r, v_s2_r, v_s3_r;
  logic [7:0] v_hold_r;
  logic [2:0] arm_r;
  logic       v_same;
  logic       sync_ok;

  // Two-stage sync, third stage for edge detection and for the sample agreement check
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {cc_s1_r, cc_s2_r, cc_s3_r} <= 3'h0;
      {ov_s1_r, ov_s2_r, ov_s3_r} <= 3'h0;
      {en_s1_r, en_s2_r}          <= 2'h0;
      v_s1_r <= 8'h00;
      v_s2_r <= 8'h00;
      v_s3_r <= 8'h00;
      v_hold_r <= 8'h00;
      arm_r  <= 3'h0;
    end else begin
      {cc_s1_r, cc_s2_r, cc_s3_r} <= {current_comparator, cc_s1_r, cc_s2_r};
      {ov_s1_r, ov_s2_r, ov_s3_r} <=
        {overvoltage_comparator, ov_s1_r, ov_s2_r};
      {en_s1_r, en_s2_r} <= {current_comparator_en, en_s1_r};
      v_s1_r <= panel_volt;
      v_s2_r <= v_s1_r;
      v_s3_r <= v_s2_r;
      v_hold_r <= v_same ? v_s2_r : v_hold_r;
      arm_r  <= {arm_r[1:0], 1'h1};
    end
  end

  // ****************************************************
  // Event decode
  // ****************************************************
  logic cc_toggle;
  logic ov_rise;
  logic ov_active;
  logic cc_event;

  // Edges count only once the chains hold real pin levels, so a pin
  // that idles high gives no false edge after reset
  assign sync_ok   = arm_r[2];
  assign cc_toggle = sync_ok && (cc_s2_r ^ cc_s3_r);
  assign ov_rise   = sync_ok && ov_s2_r && !ov_s3_r;
  // A sample changing at the sync edge may be caught half old, half
  // new; it is taken only once two synced copies agree
  assign v_same    = (v_s2_r == v_s3_r);
  assign ov_active = ov_s2_r;

  // ****************************************************
  // State
  // ****************************************************
  smpdc_state_type st_r, st_nxt;
  logic              req_r, req_nxt;
  logic              irq_en_r, irq_en_nxt;
  logic              dir_r, dir_nxt;
  logic              first_r, first_nxt;
  logic [PWR_W-1:0]  prev_r, prev_nxt;
  logic [PWR_W-1:0]  pwr_r, pwr_nxt;
  logic [WDOG_W-1:0] wd_r, wd_nxt;
  logic [7:0]        rst_cnt_r, rst_cnt_nxt;
  logic              halt_r;
  logic [DUTY_W-1:0] duty_r;
  logic              pass_done;
  logic              wd_expire;
  logic              power_rose;
  logic              track_up;
  logic              track_down;
  logic              self_rst_n;

  // ****************************************************
  // Setting register
  // ****************************************************
  smpdc_step_if stp ();

  smpdc_setting u_setting (
    .clk  (clk),
    .nrst (self_rst_n),
    .stp  (stp)
  );

  // Comparator event gated by its own enable and the mask flag
  assign cc_event  = cc_toggle && en_s2_r && irq_en_r;
  assign pass_done = (st_r == SMPDC_FINISH);
  assign wd_expire = (wd_r == WDOG_W'(WDOG_CYCLES - 1));
  assign power_rose = (pwr_r > prev_r);

  // Direction decision: sign of the power change only
  assign track_up = (st_r == SMPDC_DECIDE) &&
                    (first_r || (power_rose ? dir_r : !dir_r));
  assign track_down = (st_r == SMPDC_DECIDE) && !track_up;
  // Over-voltage trim wins over a tracking step in the same cycle
  assign stp.down = ov_rise || track_down;
  assign stp.up   = track_up && !ov_rise;

  // Next-state decode
  always_comb begin
    st_nxt    = st_r;
    pwr_nxt   = pwr_r;
    prev_nxt  = prev_r;
    dir_nxt   = dir_r;
    first_nxt = first_r;
    case (st_r)
      SMPDC_IDLE: begin
        if (req_r) begin
          st_nxt = SMPDC_CALC;
        end
      end
      SMPDC_CALC: begin
        // First pass uses setting at minimum after reset
        pwr_nxt = PWR_W'(stp.setting * v_hold_r);
        st_nxt  = SMPDC_DECIDE;
      end
      SMPDC_DECIDE: begin
        // Flag follows the step taken, an over-voltage trim included
        dir_nxt   = stp.up;
        prev_nxt  = pwr_r;
        first_nxt = 1'b0;
        st_nxt    = SMPDC_FINISH;
      end
      default: begin
        st_nxt = SMPDC_IDLE;
      end
    endcase
  end

  // ****************************************************
  // Request flag, event mask and watchdog
  // ****************************************************
  // Request flag: set wins over clear, mask re-opened at pass end
  assign req_nxt    = cc_event ? 1'b1 : (pass_done ? 1'b0 : req_r);
  assign irq_en_nxt = cc_event ? 1'b0 : (pass_done ? 1'b1 : irq_en_r);
  // Watchdog restarted by a running pass, and held at zero while its own reset pulse runs
  assign wd_nxt = (st_r == SMPDC_CALC) ? '0 : wd_r + 1'b1;
  assign rst_cnt_nxt = (rst_cnt_r != 8'h00) ? rst_cnt_r - 8'h01 :
                       (wd_expire ? PULSE_CYC : 8'h00);

  // Internal reset: pin reset or watchdog pulse. Taken from the pulse
  // flop, not a counter decode, so the reset net cannot glitch
  assign self_rst_n = nrst && !wdog_reset;

  // Watchdog and reset pulse, only pin reset clears them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_r      <= '0;
      rst_cnt_r <= 8'h00;
      wdog_reset <= 1'b0;
    end else begin
      wd_r      <= (rst_cnt_r != 8'h00) ? '0 : wd_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      wdog_reset <= (rst_cnt_nxt != 8'h00);
    end
  end

  // Control state, cleared by either reset source
  always_ff @(posedge clk or negedge self_rst_n) begin
    if (!self_rst_n) begin
      st_r     <= SMPDC_IDLE;
      req_r    <= 1'b0;
      irq_en_r <= 1'b1;
      dir_r    <= 1'b0;
      first_r  <= 1'b1;
      prev_r   <= PWR_RST;
      pwr_r    <= PWR_RST;
    end else begin
      st_r     <= st_nxt;
      req_r    <= req_nxt;
      irq_en_r <= irq_en_nxt;
      dir_r    <= dir_nxt;
      first_r  <= first_nxt;
      prev_r   <= prev_nxt;
      pwr_r    <= pwr_nxt;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge self_rst_n) begin
    if (!self_rst_n) begin
      halt_r <= 1'b0;
      duty_r <= {SET_MIN, DUTY_LSB};
    end else begin
      halt_r <= ov_active;
      duty_r <= {stp.setting, DUTY_LSB};
    end
  end

  assign duty_out     = duty_r;
  assign osc_halt     = halt_r;
  assign dither_req   = req_r;
  assign cmp_event_en = irq_en_r;
  assign dir_up       = dir_r;
  assign power_prev   = prev_r;

endmodule : smpdc_top
